// [design/mfc_pkg.sv]
/*
 * Shared constants and types of the per-SA frame format classifier.
 * Assumes a byte-wide frame stream without preamble and FCS, DA first.
 */
// Overview of operation
// - Per-SA field enables gate classification field set
// - Standard transmit offers DA, SA, Etype, tags
// - Standard receive offers only DA, SA, SecTAG
// - Standard SecTAG sits directly after source address
// - Single bypass keeps outer tag ahead, classifiable
// - Dual bypass keeps both tags ahead, classifiable
// - One-label EoMPLS header stays clear and classifiable
// - Two-label EoMPLS header stays clear and classifiable
// - Per-SA 128 or 256 bit key selection
// - Bypassed tags excluded from encryption and ICV
// - MPLS link header excluded, client fully transformed
package mfc_pkg;

  // ----------------------------------------------------------------
  // Header window and byte positions
  // ----------------------------------------------------------------
  localparam int HDR_LEN = 24;
  localparam int POS_DA = 0;
  localparam int POS_SA = 6;
  localparam int POS_T1 = 12;
  localparam int POS_V1 = 14;
  localparam int POS_T2 = 16;
  localparam int POS_V2 = 18;
  localparam int POS_ET2 = 20;
  localparam int POS_L1 = 14;
  localparam int POS_L2 = 18;
  localparam int LBL_BOS_BIT = 8;

  // ----------------------------------------------------------------
  // Ethertypes
  // ----------------------------------------------------------------
  localparam logic [15:0] ET_CTAG = 16'h8100;
  localparam logic [15:0] ET_STAG = 16'h88A8;
  localparam logic [15:0] ET_MPLS = 16'h8847;
  localparam logic [15:0] ET_SECTAG = 16'h88E5;

  // ----------------------------------------------------------------
  // Transform offsets in bytes
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_ADDR_END = 8'h0C;
  localparam logic [7:0] OFS_ONE_TAG = 8'h10;
  localparam logic [7:0] OFS_TWO_TAG = 8'h14;
  localparam logic [7:0] OFS_MPLS_BASE = 8'h0E;
  localparam logic [7:0] LEN_TAG = 8'h04;
  localparam logic [7:0] LEN_NONE = 8'h00;

  // ----------------------------------------------------------------
  // Classification field mask bits
  // ----------------------------------------------------------------
  localparam int NFLD = 10;
  localparam int F_DA = 0;
  localparam int F_SA = 1;
  localparam int F_ETYPE = 2;
  localparam int F_TPID1 = 3;
  localparam int F_VID1 = 4;
  localparam int F_TPID2 = 5;
  localparam int F_VID2 = 6;
  localparam int F_LBL1 = 7;
  localparam int F_LBL2 = 8;
  localparam int F_SECTAG = 9;

  typedef enum logic [1:0] {
    MFC_FMT_STD = 2'h0,
    MFC_FMT_ONE_TAG = 2'h1,
    MFC_FMT_TWO_TAG = 2'h2,
    MFC_FMT_MPLS = 2'h3
  } mfc_fmt_t;

  typedef enum logic [1:0] {
    MFC_ST_IDLE = 2'h0,
    MFC_ST_COLLECT = 2'h1,
    MFC_ST_EVAL = 2'h3,
    MFC_ST_SKIP = 2'h2
  } mfc_state_t;

endpackage

// [design/mfc_fmt_plan.sv]
/*
 * Combinational format plan: field visibility, SecTAG offset and the
 * region left outside encryption and ICV for one frame.
 * Assumes the parsed tag and label counts are stable while read.
 */
`timescale 1ns/1ns
module mfc_fmt_plan (
  input wire logic [1:0] i_fmt,
  input wire logic i_dir_rx,
  input wire logic [1:0] i_tag_cnt,
  input wire logic [1:0] i_lbl_cnt,
  input wire logic [mfc_pkg::NFLD-1:0] i_fld_en,
  output logic [mfc_pkg::NFLD-1:0] o_mask,
  output logic [7:0] o_sectag_ofs,
  output logic [7:0] o_skip_ofs,
  output logic [7:0] o_skip_len,
  output logic o_fmt_err
);

  logic [mfc_pkg::NFLD-1:0] tx_tags;
  logic [mfc_pkg::NFLD-1:0] raw;
  logic [7:0] mpls_len;

  always_comb begin
    tx_tags = '0;
    tx_tags[mfc_pkg::F_DA] = 1'b1;
    tx_tags[mfc_pkg::F_SA] = 1'b1;
    tx_tags[mfc_pkg::F_ETYPE] = 1'b1;
    tx_tags[mfc_pkg::F_TPID1] = (i_tag_cnt != 2'h0);
    tx_tags[mfc_pkg::F_VID1] = (i_tag_cnt != 2'h0);
    tx_tags[mfc_pkg::F_TPID2] = (i_tag_cnt == 2'h2);
    tx_tags[mfc_pkg::F_VID2] = (i_tag_cnt == 2'h2);
    mpls_len = mfc_pkg::OFS_MPLS_BASE + {4'h0, i_lbl_cnt, 2'h0};
    // Standard placement is the fallback when the frame lacks what
    // the chosen format needs; such frames are flagged, not dropped.
    raw = '0;
    raw[mfc_pkg::F_DA] = 1'b1;
    raw[mfc_pkg::F_SA] = 1'b1;
    raw[mfc_pkg::F_SECTAG] = 1'b1;
    o_sectag_ofs = mfc_pkg::OFS_ADDR_END;
    o_skip_ofs = mfc_pkg::OFS_ADDR_END;
    o_skip_len = mfc_pkg::LEN_NONE;
    o_fmt_err = 1'b0;
    unique case (mfc_pkg::mfc_fmt_t'(i_fmt))
      mfc_pkg::MFC_FMT_STD: begin
      end
      mfc_pkg::MFC_FMT_ONE_TAG: begin
        if (i_tag_cnt != 2'h0) begin
          o_sectag_ofs = mfc_pkg::OFS_ONE_TAG;
          o_skip_len = mfc_pkg::LEN_TAG;
          raw[mfc_pkg::F_TPID1] = 1'b1;
          raw[mfc_pkg::F_VID1] = 1'b1;
        end else begin
          o_fmt_err = 1'b1;
        end
      end
      mfc_pkg::MFC_FMT_TWO_TAG: begin
        if (i_tag_cnt == 2'h2) begin
          o_sectag_ofs = mfc_pkg::OFS_TWO_TAG;
          o_skip_len = mfc_pkg::LEN_TAG + mfc_pkg::LEN_TAG;
          raw[mfc_pkg::F_TPID1] = 1'b1;
          raw[mfc_pkg::F_VID1] = 1'b1;
          raw[mfc_pkg::F_TPID2] = 1'b1;
          raw[mfc_pkg::F_VID2] = 1'b1;
        end else begin
          o_fmt_err = 1'b1;
        end
      end
      mfc_pkg::MFC_FMT_MPLS: begin
        if (i_lbl_cnt != 2'h0) begin
          o_sectag_ofs = mpls_len;
          o_skip_ofs = mfc_pkg::LEN_NONE;
          o_skip_len = mpls_len;
          raw[mfc_pkg::F_ETYPE] = 1'b1;
          raw[mfc_pkg::F_LBL1] = 1'b1;
          raw[mfc_pkg::F_LBL2] = (i_lbl_cnt == 2'h2);
          tx_tags = raw;
          tx_tags[mfc_pkg::F_SECTAG] = 1'b0;
        end else begin
          o_fmt_err = 1'b1;
        end
      end
    endcase
    o_mask = (i_dir_rx ? raw : tx_tags) & i_fld_en;
  end

endmodule

// [design/mfc_classifier.sv]
/*
 * Per-SA frame format classifier: collects the first header bytes of
 * each frame, picks the SA's format and publishes classification fields,
 * SecTAG position and the bypassed header region.
 * Assumes frames arrive one byte per valid cycle, SOF on the first byte.
 */
`timescale 1ns/1ns
module mfc_classifier #(
  parameter int N_SA = 16
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_valid,
  input wire logic [7:0] i_data,
  input wire logic i_sof,
  input wire logic i_eof,
  input wire logic i_dir_rx,
  input wire logic [$clog2(N_SA)-1:0] i_sa_idx,
  input wire logic [2*N_SA-1:0] i_sa_fmt,
  input wire logic [mfc_pkg::NFLD*N_SA-1:0] i_sa_fld_en,
  input wire logic [N_SA-1:0] i_sa_key256,
  output logic o_cls_valid,
  output logic [$clog2(N_SA)-1:0] o_sa_idx,
  output logic [1:0] o_fmt,
  output logic o_key256,
  output logic [mfc_pkg::NFLD-1:0] o_fld_mask,
  output logic [47:0] o_da,
  output logic [47:0] o_sa,
  output logic [15:0] o_etype,
  output logic [15:0] o_tpid1,
  output logic [11:0] o_vid1,
  output logic [15:0] o_tpid2,
  output logic [11:0] o_vid2,
  output logic [31:0] o_lbl1,
  output logic [31:0] o_lbl2,
  output logic [1:0] o_tag_cnt,
  output logic [1:0] o_lbl_cnt,
  output logic [7:0] o_sectag_ofs,
  output logic [7:0] o_skip_ofs,
  output logic [7:0] o_skip_len,
  output logic o_sectag_ok,
  output logic o_fmt_err
);

  localparam int SA_W = $clog2(N_SA);
  localparam int CNT_W = $clog2(mfc_pkg::HDR_LEN + 1);

  // ----------------------------------------------------------------
  // Header collection
  // ----------------------------------------------------------------
  mfc_pkg::mfc_state_t state_ff;
  mfc_pkg::mfc_state_t nxt_state;
  logic [7:0] hdr_ff [0:mfc_pkg::HDR_LEN-1];
  logic [CNT_W-1:0] cnt_ff;
  logic ended_ff;
  logic dir_ff;
  logic [SA_W-1:0] sa_ff;
  logic start;
  logic take;
  logic last_hdr;

  function automatic logic [15:0] be16(input int pos);
    be16 = {hdr_ff[pos], hdr_ff[pos+1]};
  endfunction

  function automatic logic is_vlan(input logic [15:0] tpid);
    is_vlan = (tpid == mfc_pkg::ET_CTAG) || (tpid == mfc_pkg::ET_STAG);
  endfunction

  // A new frame may start in the evaluation cycle so back-to-back frames
  // are not missed; the array is read there before being overwritten.
  assign start = i_valid && i_sof &&
    ((state_ff == mfc_pkg::MFC_ST_IDLE) ||
     ((state_ff == mfc_pkg::MFC_ST_EVAL) && ended_ff));
  assign take = i_valid && (state_ff == mfc_pkg::MFC_ST_COLLECT);
  assign last_hdr = take &&
    ((cnt_ff == CNT_W'(mfc_pkg::HDR_LEN - 1)) || i_eof);

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      mfc_pkg::MFC_ST_IDLE: begin
        if (start) nxt_state = mfc_pkg::MFC_ST_COLLECT;
      end
      mfc_pkg::MFC_ST_COLLECT: begin
        if (last_hdr) nxt_state = mfc_pkg::MFC_ST_EVAL;
      end
      mfc_pkg::MFC_ST_EVAL: begin
        if (start) nxt_state = mfc_pkg::MFC_ST_COLLECT;
        else if (ended_ff) nxt_state = mfc_pkg::MFC_ST_IDLE;
        else if (i_valid && i_eof) nxt_state = mfc_pkg::MFC_ST_IDLE;
        else nxt_state = mfc_pkg::MFC_ST_SKIP;
      end
      mfc_pkg::MFC_ST_SKIP: begin
        if (i_valid && i_eof) nxt_state = mfc_pkg::MFC_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_ff <= mfc_pkg::MFC_ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_ff <= '0;
      ended_ff <= 1'b0;
      dir_ff <= 1'b0;
      sa_ff <= '0;
    end else if (start) begin
      cnt_ff <= CNT_W'(1);
      ended_ff <= i_eof;
      dir_ff <= i_dir_rx;
      sa_ff <= i_sa_idx;
    end else if (take) begin
      cnt_ff <= cnt_ff + CNT_W'(1);
      ended_ff <= i_eof;
    end
  end

  // Short frames leave stale bytes beyond their end; those bytes are parsed
  // as header, and o_fmt_err flags such frames only when a format check fails.
  always_ff @(posedge i_clk_sys) begin
    if (start) begin
      hdr_ff[0] <= i_data;
    end else if (take && (cnt_ff < CNT_W'(mfc_pkg::HDR_LEN))) begin
      hdr_ff[cnt_ff] <= i_data;
    end
  end

  // ----------------------------------------------------------------
  // Header parse and format plan
  // ----------------------------------------------------------------
  logic tag1;
  logic tag2;
  logic mpls;
  logic [1:0] tag_cnt;
  logic [1:0] lbl_cnt;
  logic [15:0] etype;
  logic [31:0] lbl1;
  logic [1:0] sa_fmt;
  logic [mfc_pkg::NFLD-1:0] fld_en;
  logic [mfc_pkg::NFLD-1:0] mask;
  logic [7:0] sectag_ofs;
  logic [7:0] skip_ofs;
  logic [7:0] skip_len;
  logic fmt_err;

  always_comb begin
    tag1 = is_vlan(be16(mfc_pkg::POS_T1));
    tag2 = tag1 && is_vlan(be16(mfc_pkg::POS_T2));
    mpls = (be16(mfc_pkg::POS_T1) == mfc_pkg::ET_MPLS);
    lbl1 = {be16(mfc_pkg::POS_L1), be16(mfc_pkg::POS_L1 + 2)};
    tag_cnt = tag2 ? 2'h2 : (tag1 ? 2'h1 : 2'h0);
    lbl_cnt = !mpls ? 2'h0 : (lbl1[mfc_pkg::LBL_BOS_BIT] ? 2'h1 : 2'h2);
    etype = tag2 ? be16(mfc_pkg::POS_ET2) :
            (tag1 ? be16(mfc_pkg::POS_T2) : be16(mfc_pkg::POS_T1));
  end

  assign sa_fmt = i_sa_fmt[2*sa_ff +: 2];
  assign fld_en = i_sa_fld_en[mfc_pkg::NFLD*sa_ff +: mfc_pkg::NFLD];

  mfc_fmt_plan u_plan (
    .i_fmt(sa_fmt),
    .i_dir_rx(dir_ff),
    .i_tag_cnt(tag_cnt),
    .i_lbl_cnt(lbl_cnt),
    .i_fld_en(fld_en),
    .o_mask(mask),
    .o_sectag_ofs(sectag_ofs),
    .o_skip_ofs(skip_ofs),
    .o_skip_len(skip_len),
    .o_fmt_err(fmt_err)
  );

  // ----------------------------------------------------------------
  // Result registers
  // ----------------------------------------------------------------
  logic eval;
  assign eval = (state_ff == mfc_pkg::MFC_ST_EVAL);

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_cls_valid <= 1'b0;
    end else begin
      o_cls_valid <= eval;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_sa_idx <= '0;
      o_fmt <= 2'h0;
      o_key256 <= 1'b0;
      o_fld_mask <= '0;
      o_tag_cnt <= 2'h0;
      o_lbl_cnt <= 2'h0;
      o_sectag_ofs <= 8'h00;
      o_skip_ofs <= 8'h00;
      o_skip_len <= 8'h00;
      o_sectag_ok <= 1'b0;
      o_fmt_err <= 1'b0;
    end else if (eval) begin
      o_sa_idx <= sa_ff;
      o_fmt <= sa_fmt;
      o_key256 <= i_sa_key256[sa_ff];
      o_fld_mask <= mask;
      o_tag_cnt <= tag_cnt;
      o_lbl_cnt <= lbl_cnt;
      o_sectag_ofs <= sectag_ofs;
      o_skip_ofs <= skip_ofs;
      o_skip_len <= skip_len;
      o_sectag_ok <= dir_ff && ({hdr_ff[sectag_ofs[4:0]], hdr_ff[sectag_ofs[4:0] + 5'h01]}
                     == mfc_pkg::ET_SECTAG);
      o_fmt_err <= fmt_err;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_da <= '0;
      o_sa <= '0;
      o_etype <= '0;
      o_tpid1 <= '0;
      o_vid1 <= '0;
      o_tpid2 <= '0;
      o_vid2 <= '0;
      o_lbl1 <= '0;
      o_lbl2 <= '0;
    end else if (eval) begin
      o_da <= {be16(mfc_pkg::POS_DA), be16(mfc_pkg::POS_DA + 2), be16(mfc_pkg::POS_DA + 4)};
      o_sa <= {be16(mfc_pkg::POS_SA), be16(mfc_pkg::POS_SA + 2), be16(mfc_pkg::POS_SA + 4)};
      o_etype <= mpls ? mfc_pkg::ET_MPLS : etype;
      o_tpid1 <= be16(mfc_pkg::POS_T1);
      o_vid1 <= 12'(be16(mfc_pkg::POS_V1));
      o_tpid2 <= be16(mfc_pkg::POS_T2);
      o_vid2 <= 12'(be16(mfc_pkg::POS_V2));
      o_lbl1 <= lbl1;
      o_lbl2 <= {be16(mfc_pkg::POS_L2), be16(mfc_pkg::POS_L2 + 2)};
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);

  a_cls_one_pulse: assert property (o_cls_valid |=> !o_cls_valid)
    else $error("classification valid longer than one cycle");
  a_std_sectag_pos: assert property (
    o_cls_valid && o_fmt == 2'h0 |-> o_sectag_ofs == 8'h0C && o_skip_len == 8'h00)
    else $error("standard SecTAG not right after SA");
  // In standard format only DA, SA and SecTAG may be offered before decryption
  a_rx_std_fields: assert property (
    o_cls_valid && o_fmt == 2'h0 && $past(dir_ff) |->
    (o_fld_mask & 10'h1FC) == 10'h000)
    else $error("encrypted field offered for receive classification");
  a_tx_dual_tags: assert property (
    o_cls_valid && !$past(dir_ff) && o_tag_cnt == 2'h2 &&
    o_fmt != 2'h3 && i_sa_fld_en[mfc_pkg::NFLD*o_sa_idx + mfc_pkg::F_VID2] |->
    o_fld_mask[mfc_pkg::F_VID2])
    else $error("second tag hidden from transmit classification");
  a_mask_in_enable: assert property (
    o_cls_valid |->
    (o_fld_mask & ~i_sa_fld_en[mfc_pkg::NFLD*o_sa_idx +: mfc_pkg::NFLD]) == '0)
    else $error("field used that the SA does not enable");
  a_one_tag_bypass: assert property (
    o_cls_valid && o_fmt == 2'h1 && o_tag_cnt != 2'h0 |->
    o_sectag_ofs == 8'h10 && o_skip_ofs == 8'h0C && o_skip_len == 8'h04)
    else $error("single tag bypass placement wrong");
  a_two_tag_bypass: assert property (
    o_cls_valid && o_fmt == 2'h2 && o_tag_cnt == 2'h2 |->
    o_sectag_ofs == 8'h14 && o_skip_len == 8'h08)
    else $error("dual tag bypass placement wrong");
  a_mpls_bypass: assert property (
    o_cls_valid && o_fmt == 2'h3 && o_lbl_cnt != 2'h0 |->
    o_skip_ofs == 8'h00 && o_skip_len == o_sectag_ofs &&
    o_sectag_ofs == (8'h0E + {4'h0, o_lbl_cnt, 2'h0}))
    else $error("MPLS header bypass length wrong");
  a_key_size: assert property (eval |=> o_key256 == i_sa_key256[$past(sa_ff)])
    else $error("key size not taken from the SA");

  c_std_frame: cover property (o_cls_valid && o_fmt == 2'h0);
  c_dual_bypass: cover property (o_cls_valid && o_fmt == 2'h2 && o_tag_cnt == 2'h2);
  c_mpls_two: cover property (o_cls_valid && o_fmt == 2'h3 && o_lbl_cnt == 2'h2);
  c_back_to_back: cover property (eval && start);

endmodule

// [verif/mfc_mac_model.sv]
/*
 * Host-side MAC model: streams 24-byte frame headers into the classifier.
 * Assumes the caller waits for each classification and ends a burst with idle_bus.
 */
`timescale 1ns/1ns
module mfc_mac_model #(
  parameter int N_SA = 4
) (
  input wire logic i_clk_sys,
  output logic o_valid,
  output logic [7:0] o_data,
  output logic o_sof,
  output logic o_eof,
  output logic o_dir_rx,
  output logic [$clog2(N_SA)-1:0] o_sa_idx
);
  // ----------------------------------------------------------------
  // Idle state at time zero
  // ----------------------------------------------------------------
  initial begin
    o_valid = 1'b0;
    o_data = 8'hA5;
    o_sof = 1'b0;
    o_eof = 1'b0;
    o_dir_rx = 1'b0;
    o_sa_idx = '0;
  end

  // ----------------------------------------------------------------
  // Frame driver
  // ----------------------------------------------------------------
  // No gap after the last byte, so two calls give back-to-back frames
  task automatic send(input logic [191:0] hdr, input logic [$clog2(N_SA)-1:0] sa,
                      input logic rx);
    for (int i = 0; i < 24; i++) begin
      @(negedge i_clk_sys);
      o_valid = 1'b1;
      o_sof = (i == 0);
      o_eof = (i == 23);
      o_data = hdr[191-8*i -: 8];
      if (i == 0) begin
        o_dir_rx = rx;
        o_sa_idx = sa;
      end
    end
  endtask

  // Released lines show the inverse, never a stale copy of the last byte
  task automatic idle_bus();
    @(negedge i_clk_sys);
    o_valid = 1'b0;
    o_sof = 1'b0;
    o_eof = 1'b0;
    o_data = ~o_data;
    o_dir_rx = ~o_dir_rx;
    o_sa_idx = ~o_sa_idx;
  endtask
endmodule

// [verif/macsec_format_classifier_test.sv]
/*
 * Self-checking testbench of the per-SA frame format classifier.
 * Assumes SA k is set to format code k and frames of exactly 24 bytes.
 */
`timescale 1ns/1ns
module macsec_format_classifier_test;
  localparam int N_SA = 4;
  localparam logic [47:0] DA = 48'h0A1122334455;
  localparam logic [47:0] SA = 48'h0B6677889900;
  localparam logic [3:0] KEY_CFG = 4'hA;
  localparam logic [191:0] F_UNT = {DA, SA, 16'h0800, 80'h0};
  localparam logic [191:0] F_DUAL = {DA, SA, 64'h88A801238100_0456, 16'h0800, 16'h0};
  localparam logic [191:0] F_RX_STD = {DA, SA, 16'h88E5, 80'h0};
  localparam logic [191:0] F_RX_ONE = {DA, SA, 48'h8100_0123_88E5, 48'h0};
  localparam logic [191:0] F_RX_TWO = {DA, SA, 64'h88A801238100_0456, 32'h88E5_0000};
  localparam logic [191:0] F_MPLS1 = {DA, SA, 16'h8847, 32'h12345140, 48'h0};
  localparam logic [191:0] F_MPLS2 = {DA, SA, 16'h8847, 64'h11111040_22222140, 16'h88E5};

  logic i_clk_sys, i_rst_n, i_valid, i_sof, i_eof, i_dir_rx;
  logic [7:0] i_data;
  logic [1:0] i_sa_idx, o_sa_idx, o_fmt, o_tag_cnt, o_lbl_cnt;
  logic [mfc_pkg::NFLD*N_SA-1:0] fld_en;
  logic o_cls_valid, o_key256, o_sectag_ok, o_fmt_err;
  logic [mfc_pkg::NFLD-1:0] o_fld_mask;
  logic [47:0] o_da, o_sa;
  logic [15:0] o_etype, o_tpid1, o_tpid2;
  logic [11:0] o_vid1, o_vid2;
  logic [31:0] o_lbl1, o_lbl2;
  logic [7:0] o_sectag_ofs, o_skip_ofs, o_skip_len;
  int err_count = 0;
  int checks = 0;

  // ----------------------------------------------------------------
  // Design, partner and clock
  // ----------------------------------------------------------------
  mfc_classifier #(.N_SA(N_SA)) i_dut (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
    .i_valid(i_valid), .i_data(i_data), .i_sof(i_sof), .i_eof(i_eof),
    .i_dir_rx(i_dir_rx), .i_sa_idx(i_sa_idx), .i_sa_fmt(8'hE4), .i_sa_fld_en(fld_en),
    .i_sa_key256(KEY_CFG), .o_cls_valid(o_cls_valid), .o_sa_idx(o_sa_idx), .o_fmt(o_fmt),
    .o_key256(o_key256), .o_fld_mask(o_fld_mask), .o_da(o_da), .o_sa(o_sa),
    .o_etype(o_etype), .o_tpid1(o_tpid1), .o_vid1(o_vid1), .o_tpid2(o_tpid2),
    .o_vid2(o_vid2), .o_lbl1(o_lbl1), .o_lbl2(o_lbl2), .o_tag_cnt(o_tag_cnt),
    .o_lbl_cnt(o_lbl_cnt), .o_sectag_ofs(o_sectag_ofs), .o_skip_ofs(o_skip_ofs),
    .o_skip_len(o_skip_len), .o_sectag_ok(o_sectag_ok), .o_fmt_err(o_fmt_err));
  mfc_mac_model #(.N_SA(N_SA)) i_mac (.i_clk_sys(i_clk_sys), .o_valid(i_valid),
    .o_data(i_data), .o_sof(i_sof), .o_eof(i_eof), .o_dir_rx(i_dir_rx),
    .o_sa_idx(i_sa_idx));

  initial begin
    i_clk_sys = 1'b0;
    forever #4 i_clk_sys = ~i_clk_sys;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  // The pulse stands one cycle, so it is sampled just after every edge
  task automatic wait_cls();
    int n = 0;
    @(posedge i_clk_sys);
    #1;
    while (o_cls_valid !== 1'b1 && n < 40) begin
      @(posedge i_clk_sys);
      #1;
      n++;
    end
    chk("cls_valid", o_cls_valid, 1'b1);
  endtask

  task automatic chk_common(input int sa, input logic [9:0] mask, input logic [7:0] ofs,
                            input logic [7:0] sko, input logic [7:0] skl, input logic err);
    chk("sa_idx", o_sa_idx, sa[1:0]);
    chk("fmt", o_fmt, sa[1:0]);
    chk("key256", o_key256, KEY_CFG[sa]);
    chk("fld_mask", o_fld_mask, mask);
    chk("sectag_ofs", o_sectag_ofs, ofs);
    chk("skip_ofs", o_skip_ofs, sko);
    chk("skip_len", o_skip_len, skl);
    chk("fmt_err", o_fmt_err, err);
    chk("da", o_da, DA);
    chk("sa", o_sa, SA);
  endtask

  task automatic frame(input logic [191:0] hdr, input int sa, input logic rx);
    fork
      begin
        i_mac.send(hdr, sa[1:0], rx);
        i_mac.idle_bus();
      end
      wait_cls();
    join
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_std_tx();
    @(negedge i_clk_sys);
    fld_en[9:0] = 10'h3FD;
    frame(F_UNT, 0, 1'b0);
    chk_common(0, 10'h005, 8'h0C, 8'h0C, 8'h00, 1'b0);
    chk("etype", o_etype, 16'h0800);
    @(negedge i_clk_sys);
    fld_en[9:0] = 10'h3FF;
    frame(F_DUAL, 0, 1'b0);
    chk_common(0, 10'h07F, 8'h0C, 8'h0C, 8'h00, 1'b0);
    chk("tpid_vid", {o_tpid1, 4'h0, o_vid1, o_tpid2, 4'h0, o_vid2},
        64'h88A8_0123_8100_0456);
    chk("tag_cnt", o_tag_cnt, 2'h2);
    chk("etype", o_etype, 16'h0800);
  endtask

  task automatic t_std_rx();
    frame(F_RX_STD, 0, 1'b1);
    chk_common(0, 10'h203, 8'h0C, 8'h0C, 8'h00, 1'b0);
    chk("sectag_ok", o_sectag_ok, 1'b1);
    frame(F_UNT, 0, 1'b1);
    chk("sectag_ok", o_sectag_ok, 1'b0);
  endtask

  task automatic t_one_tag();
    frame(F_RX_ONE, 1, 1'b1);
    chk_common(1, 10'h21B, 8'h10, 8'h0C, 8'h04, 1'b0);
    chk("sectag_ok", o_sectag_ok, 1'b1);
    chk("tpid1_vid1", {o_tpid1, o_vid1}, {16'h8100, 12'h123});
    frame(F_DUAL, 1, 1'b0);
    chk_common(1, 10'h07F, 8'h10, 8'h0C, 8'h04, 1'b0);
  endtask

  // Second SOF lands in the eval cycle of the first frame
  task automatic t_two_tag_b2b();
    fork
      begin
        i_mac.send(F_RX_TWO, 2'h2, 1'b1);
        i_mac.send(F_UNT, 2'h2, 1'b0);
        i_mac.idle_bus();
      end
      begin
        wait_cls();
        chk_common(2, 10'h27B, 8'h14, 8'h0C, 8'h08, 1'b0);
        chk("sectag_ok", o_sectag_ok, 1'b1);
        chk("tpid2_vid2", {o_tpid2, o_vid2}, {16'h8100, 12'h456});
        wait_cls();
        chk_common(2, 10'h007, 8'h0C, 8'h0C, 8'h00, 1'b1);
      end
    join
  endtask

  task automatic t_mpls();
    frame(F_MPLS1, 3, 1'b0);
    chk_common(3, 10'h087, 8'h12, 8'h00, 8'h12, 1'b0);
    chk("lbl1", o_lbl1, 32'h12345140);
    chk("lbl_cnt", o_lbl_cnt, 2'h1);
    chk("etype", o_etype, 16'h8847);
    frame(F_MPLS2, 3, 1'b1);
    chk_common(3, 10'h387, 8'h16, 8'h00, 8'h16, 1'b0);
    chk("lbls", {o_lbl1, o_lbl2}, 64'h11111040_22222140);
    chk("lbl_cnt", o_lbl_cnt, 2'h2);
    chk("sectag_ok", o_sectag_ok, 1'b1);
  endtask

  // ----------------------------------------------------------------
  // Verdict, watchdog and main sequence
  // ----------------------------------------------------------------
  task automatic give_verdict();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Ten short frames need under 300 cycles; this leaves ample margin
  initial begin
    #20000;
    err_count++;
    give_verdict();
  end

  initial begin
    i_rst_n = 1'b0;
    fld_en = '1;
    repeat (12) @(negedge i_clk_sys);
    chk("rst_valid", o_cls_valid, 1'b0);
    chk("rst_mask", o_fld_mask, 10'h000);
    i_rst_n = 1'b1;
    t_std_tx();
    t_std_rx();
    t_one_tag();
    t_two_tag_b2b();
    t_mpls();
    give_verdict();
  end
endmodule
